// ==== ddrac_bank.sv ====
// One bank's open-row tracker
`timescale 1ns/100ps
module ddrac_bank #(
    parameter int ROW_W = 14
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    input  wire logic              i_open,
    input  wire logic              i_close,
    input  wire logic [ROW_W-1:0]  i_row,
    output logic                   o_open,
    output logic [ROW_W-1:0]       o_row
);
    import ddrac_pkg::*;

    logic             open_q;
    logic             open_d;
    logic [ROW_W-1:0] row_q;
    logic [ROW_W-1:0] row_d;

    always_comb begin
        open_d = open_q;
        row_d  = row_q;
        if (i_open) begin
            open_d = 1'b1;
            row_d  = i_row;
        end else if (i_close) begin
            open_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            open_q <= BANK_RST;
            row_q  <= '0;
        end else if (i_ce) begin
            open_q <= open_d;
            row_q  <= row_d;
        end
    end

    assign o_open = open_q;
    assign o_row  = row_q;
endmodule // ddrac_bank

// ==== ddrac_ctrl_model.sv ====
// Controller model driving command, address and clock enable
`timescale 1ns/100ps
module ddrac_ctrl_model (
    input  wire logic              i_clk,
    output ddrac_pkg::ddrac_pins_s o_pins
);
    import ddrac_pkg::*;

    initial begin
        o_pins = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
    end

    // This task and issue both move clock enable, never inside an access
    task automatic set_cke(input logic v);
        @(posedge i_clk);
        o_pins.cke <= v;
    endtask

    // One command, then deselect with inverted address so stale values never pass
    task automatic issue(input logic cke, input logic cs_n, input logic [2:0] code,
                         input logic [2:0] ba, input logic [13:0] addr, input logic term);
        @(posedge i_clk);
        o_pins <= '{cke: cke, cs_n: cs_n, ras_n: code[2], cas_n: code[1], we_n: code[0],
                    ba: ba, addr: addr, termination_on: term};
        @(posedge i_clk);
        o_pins <= '{cke: cke, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                    ba: ~ba, addr: ~addr, termination_on: term};
    endtask
endmodule // ddrac_ctrl_model

// ==== ddrac_pkg.sv ====
// Constants, types and command codes for the DDR3 address and control input block
// Notes on behaviour
// - Eight banks by three bank bits; rows 14 bits (x8) or 13 (x16); columns 10.
// - Page bytes are two to the column bits times width over eight.
// - Activate loads the addressed row of the selected bank into its sense amplifiers.
// - Every address and control input is sampled on the rising clock edge.
// - Clock enable high keeps clocks, input buffers and drivers on; low turns them off. Here power-down leaves the command buffers on.
// - Clock enable low: idle banks give precharge power-down or self-refresh, else active.
// - A rise of clock enable ends self-refresh without a clock edge. Here exit waits on a clocked two-flop synchronizer.
// - In self-refresh only clock, termination, clock enable and reset buffers stay on.
// - A command is ignored when the active-low rank select is sampled high.
// - Read or write with the close-after-access bit high precharges that bank afterwards.
// - Precharge closes the selected bank, or all banks when that bit is high.
// - Read or write chops the burst when the chop request is sampled low.
package ddrac_pkg;

    localparam int NUM_BANKS     = 8;
    localparam int BA_W          = 3;
    localparam int ADDR_W        = 14;
    localparam int COL_W         = 10;
    localparam int ORG_X8        = 8;
    localparam int ROW_W_X8      = 14;
    localparam int ROW_W_X16     = 13;
    localparam int AUTO_PRE_BIT  = 10;
    localparam int CHOP_BIT      = 12;
    localparam int PAGE_W        = 12;

    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;

    typedef struct packed {
        logic              cke;
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] addr;
        logic              termination_on;
    } ddrac_pins_s;

    typedef struct packed {
        logic              valid;
        logic [BA_W-1:0]   bank;
        logic [ADDR_W-1:0] row;
    } ddrac_act_s;

    typedef struct packed {
        logic             valid;
        logic             write;
        logic [BA_W-1:0]  bank;
        logic [COL_W-1:0] col;
        logic             close_after_access;
        logic             chop;
    } ddrac_acc_s;

    typedef enum logic [1:0] {
        DDRAC_ACTIVE = 2'h0,
        DDRAC_APD    = 2'h1,
        DDRAC_PPD    = 2'h3,
        DDRAC_SREF   = 2'h2
    } ddrac_pwr_e;

    // Deselect with clock enable high, else reset looks like power-down entry
    localparam ddrac_pins_s PINS_IDLE = 23'h7C0000;
    localparam ddrac_act_s  ACT_RST   = '0;
    localparam ddrac_acc_s  ACC_RST   = '0;
    localparam ddrac_pwr_e  PWR_RST   = DDRAC_ACTIVE;
    localparam logic        BANK_RST  = 1'b0;

endpackage

// ==== ddrac_top.sv ====
// Address decode, command masking and clock-enable power states
`timescale 1ns/100ps
module ddrac_top #(
    parameter int ORG = 8
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    input  wire logic                        i_ce,
    input  wire ddrac_pkg::ddrac_pins_s      i_pins,
    output ddrac_pkg::ddrac_act_s            o_act,
    output ddrac_pkg::ddrac_acc_s            o_access,
    output logic [ddrac_pkg::NUM_BANKS-1:0]  o_bank_open,
    output ddrac_pkg::ddrac_pwr_e            o_pwr,
    output logic                             o_clocks_on,
    output logic                             o_cmd_buf_on,
    output logic                             o_term_on,
    output logic [ddrac_pkg::PAGE_W-1:0]     o_page_bytes
);
    import ddrac_pkg::*;

    localparam int ROW_W = (ORG == ORG_X8) ? ROW_W_X8 : ROW_W_X16;
    localparam int PAGE_BYTES = (1 << COL_W) * ORG / 8;
    localparam logic [ADDR_W-1:0] ROW_MASK = ADDR_W'((1 << ROW_W) - 1);

    ddrac_pins_s           pins_q;
    logic                  cke_s1_q;
    logic                  cke_s2_q;
    ddrac_pwr_e            pwr_q;
    ddrac_pwr_e            pwr_d;
    ddrac_act_s            act_q;
    ddrac_act_s            act_d;
    ddrac_acc_s            acc_q;
    ddrac_acc_s            acc_d;
    logic [NUM_BANKS-1:0]  ap_pend_q;
    logic [NUM_BANKS-1:0]  ap_pend_d;
    logic                  clk_on_q;
    logic                  buf_on_q;
    logic                  term_q;
    logic [PAGE_W-1:0]     page_q;

    logic                  cmd_ok;
    logic [2:0]            cmd;
    logic                  is_act;
    logic                  is_rw;
    logic                  is_pre;
    logic                  sref_req;
    logic [NUM_BANKS-1:0]  sel;
    logic [NUM_BANKS-1:0]  open_v;
    logic [NUM_BANKS-1:0]  close_v;
    logic [NUM_BANKS-1:0]  bank_open;
    logic [ADDR_W-1:0]     row_m;
    logic                  chop_in;

    // Activate, access and precharge only while awake, clock enable high and rank selected; self-refresh needs rank select only
    always_comb begin
        cmd      = {pins_q.ras_n, pins_q.cas_n, pins_q.we_n};
        cmd_ok   = (pwr_q == DDRAC_ACTIVE) && pins_q.cke && !pins_q.cs_n;
        is_act   = cmd_ok && (cmd == CMD_ACT);
        is_rw    = cmd_ok && ((cmd == CMD_RD) || (cmd == CMD_WR));
        is_pre   = cmd_ok && (cmd == CMD_PRE);
        sref_req = !pins_q.cs_n && (cmd == CMD_REF);
        sel      = NUM_BANKS'(1'b1) << pins_q.ba;
        row_m    = pins_q.addr & ROW_MASK;
        chop_in  = !pins_q.addr[CHOP_BIT];
        open_v   = is_act ? sel : '0;
        close_v  = ap_pend_q;
        if (is_pre) begin
            close_v = close_v | (pins_q.addr[AUTO_PRE_BIT] ? '1 : sel);
        end
    end

    // Access and activate strobes; auto-precharge lands one cycle later
    always_comb begin
        act_d      = ACT_RST;
        acc_d      = ACC_RST;
        ap_pend_d  = '0;
        act_d.valid = is_act;
        act_d.bank  = pins_q.ba;
        act_d.row   = row_m;
        if (is_rw) begin
            acc_d.valid              = 1'b1;
            acc_d.write              = (cmd == CMD_WR);
            acc_d.bank               = pins_q.ba;
            acc_d.col                = pins_q.addr[COL_W-1:0];
            acc_d.close_after_access = pins_q.addr[AUTO_PRE_BIT];
            acc_d.chop               = chop_in;
            if (pins_q.addr[AUTO_PRE_BIT]) begin
                ap_pend_d = sel;
            end
        end
    end

    // Power states; the controller never drops clock enable mid-access
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            DDRAC_ACTIVE: begin
                if (!pins_q.cke) begin
                    if (|bank_open) begin
                        pwr_d = DDRAC_APD;
                    end else if (sref_req) begin
                        pwr_d = DDRAC_SREF;
                    end else begin
                        pwr_d = DDRAC_PPD;
                    end
                end
            end
            DDRAC_APD, DDRAC_PPD: begin
                if (pins_q.cke) begin
                    pwr_d = DDRAC_ACTIVE;
                end
            end
            DDRAC_SREF: begin
                // Exit rides the clocked two-flop clock enable synchronizer, not the sampled pins
                if (cke_s2_q) begin
                    pwr_d = DDRAC_ACTIVE;
                end
            end
            default: pwr_d = PWR_RST;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pins_q    <= PINS_IDLE;
            cke_s1_q  <= 1'b0;
            cke_s2_q  <= 1'b0;
            pwr_q     <= PWR_RST;
            act_q     <= ACT_RST;
            acc_q     <= ACC_RST;
            ap_pend_q <= '0;
            clk_on_q  <= 1'b1;
            buf_on_q  <= 1'b1;
            term_q    <= 1'b0;
            page_q    <= '0;
        end else if (i_ce) begin
            pins_q    <= i_pins;
            cke_s1_q  <= i_pins.cke;
            cke_s2_q  <= cke_s1_q;
            pwr_q     <= pwr_d;
            act_q     <= act_d;
            acc_q     <= acc_d;
            ap_pend_q <= ap_pend_d;
            clk_on_q  <= (pwr_d == DDRAC_ACTIVE);
            buf_on_q  <= (pwr_d != DDRAC_SREF);
            term_q    <= pins_q.termination_on;
            page_q    <= PAGE_W'(PAGE_BYTES);
        end
    end

    // Per-bank row trackers
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
            ddrac_bank #(
                .ROW_W (ROW_W)
            ) u_bank (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_ce    (i_ce),
                .i_open  (open_v[gi]),
                .i_close (close_v[gi]),
                .i_row   (row_m[ROW_W-1:0]),
                .o_open  (bank_open[gi]),
                .o_row   ()
            );
        end
    endgenerate

    assign o_act        = act_q;
    assign o_access     = acc_q;
    assign o_bank_open  = bank_open;
    assign o_pwr        = pwr_q;
    assign o_clocks_on  = clk_on_q;
    assign o_cmd_buf_on = buf_on_q;
    assign o_term_on    = term_q;
    assign o_page_bytes = page_q;

    // Checks count only enabled edges, since a low enable freezes everything
    default clocking cb @(posedge i_clk iff i_ce);
    endclocking
    default disable iff (i_rst);

    sequence s_rw_close;
        is_rw && pins_q.addr[AUTO_PRE_BIT];
    endsequence

    sequence s_pend_then_closed;
        (ap_pend_q != '0) ##1 ((bank_open & $past(ap_pend_q)) == '0);
    endsequence

    a_cs_mask_cmd: assert property (pins_q.cs_n |=> !act_q.valid && !acc_q.valid)
        else $error("command accepted while rank deselected");
    a_act_opens_row: assert property (is_act |=> act_q.valid && act_q.row == $past(row_m)
        && bank_open[act_q.bank])
        else $error("activate did not open the addressed row");
    a_row_width: assert property (act_q.valid |-> (act_q.row & ~ROW_MASK) == '0)
        else $error("row address wider than organisation");
    a_page_size: assert property ($past(i_rst) == 1'b0 |-> o_page_bytes == PAGE_W'(PAGE_BYTES))
        else $error("page size wrong");
    a_chop_flag: assert property (is_rw |=> acc_q.valid && acc_q.chop == $past(chop_in))
        else $error("burst chop not taken from address bit");
    a_auto_pre: assert property (s_rw_close |=> s_pend_then_closed)
        else $error("bank not closed after access");
    a_pre_all: assert property (is_pre && pins_q.addr[AUTO_PRE_BIT] |=> bank_open == '0)
        else $error("precharge all left a bank open");
    a_apd_entry: assert property (pwr_q == DDRAC_ACTIVE && !pins_q.cke && (|bank_open)
        |=> pwr_q == DDRAC_APD)
        else $error("open bank did not enter active power-down");
    a_sref_exit: assert property (pwr_q == DDRAC_SREF && cke_s2_q |=> pwr_q == DDRAC_ACTIVE
        ##0 o_clocks_on)
        else $error("self-refresh exit missed");
    a_sref_bufs: assert property (pwr_q == DDRAC_SREF |-> !o_cmd_buf_on && !o_clocks_on)
        else $error("input buffers on in self-refresh");
    a_clk_gate: assert property (pwr_q != DDRAC_ACTIVE |-> !o_clocks_on ##1 !act_q.valid)
        else $error("clocks on while powered down");
    a_sample_pins: assert property (1'b1 |=> pins_q == $past(i_pins))
        else $error("pins not sampled on rising edge");

endmodule // ddrac_top

// ==== ddrac_top_tb_top.sv ====
// Self-checking testbench for the address and control input block
`timescale 1ns/100ps
module ddrac_top_tb_top;
    import ddrac_pkg::*;

    logic                 clk;
    logic                 rst;
    logic                 ce;
    ddrac_pins_s          pins;
    ddrac_act_s           act;
    ddrac_acc_s           acc;
    logic [NUM_BANKS-1:0] banks;
    ddrac_pwr_e           pwr;
    logic                 clocks_on;
    logic                 cmd_buf_on;
    logic                 term_on;
    logic [PAGE_W-1:0]    page_bytes;
    ddrac_act_s           act16;
    logic [PAGE_W-1:0]    page16;
    int                   errors;
    int                   compares;

    ddrac_ctrl_model i_ctrl (.i_clk(clk), .o_pins(pins));

    ddrac_top #(.ORG(8)) i_dut (
        .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_pins(pins), .o_act(act), .o_access(acc),
        .o_bank_open(banks), .o_pwr(pwr), .o_clocks_on(clocks_on),
        .o_cmd_buf_on(cmd_buf_on), .o_term_on(term_on), .o_page_bytes(page_bytes)
    );

    // Wide organisation, to see the shorter row mask and the larger page
    ddrac_top #(.ORG(16)) i_dut_x16 (
        .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_pins(pins), .o_act(act16), .o_access(),
        .o_bank_open(), .o_pwr(), .o_clocks_on(), .o_cmd_buf_on(), .o_term_on(),
        .o_page_bytes(page16)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic finish_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // Bounded wait; sel 0 act strobe, 1 access strobe, 2 banks, 3 power state
    task automatic wait_on(input int sel, input logic [7:0] exp, input string msg);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 6 && !hit; i++) begin
            @(posedge clk);
            #1;
            case (sel)
                0: hit = (act.valid === 1'b1);
                1: hit = (acc.valid === 1'b1);
                2: hit = (banks === exp);
                default: hit = (pwr === ddrac_pwr_e'(exp[1:0]));
            endcase
        end
        chk(hit, msg);
        if (!hit) finish_test();
    endtask

    task automatic t_reset();
        chk(page_bytes === 12'((1 << COL_W) * ORG_X8 / 8), "page size");
        chk(page16 === 12'((1 << COL_W) * 16 / 8), "x16 page size");
        chk(banks === 8'h00 && pwr === DDRAC_ACTIVE && clocks_on === 1'b1, "reset state");
    endtask

    task automatic t_act_read();
        i_ctrl.issue(1'b1, 1'b0, CMD_ACT, 3'h2, 14'h3ABC, 1'b0);
        wait_on(0, 8'h00, "no activate");
        chk(act.bank === 3'h2 && act.row === 14'h3ABC, "act fields");
        chk(act16.valid === 1'b1 && act16.row === 14'h1ABC, "x16 row mask");
        wait_on(2, 8'h04, "row not open");
        i_ctrl.issue(1'b1, 1'b0, CMD_RD, 3'h2, 14'h06C5, 1'b0);
        wait_on(1, 8'h00, "no read");
        chk(acc.write === 1'b0 && acc.bank === 3'h2 && acc.col === 10'h2C5, "rd fields");
        chk(acc.close_after_access === 1'b1 && acc.chop === 1'b1, "rd ap/chop");
        wait_on(2, 8'h00, "no auto close");
    endtask

    task automatic t_precharge();
        i_ctrl.issue(1'b1, 1'b0, CMD_ACT, 3'h1, 14'h0011, 1'b0);
        i_ctrl.issue(1'b1, 1'b0, CMD_ACT, 3'h5, 14'h0055, 1'b0);
        wait_on(2, 8'h22, "two rows");
        i_ctrl.issue(1'b1, 1'b0, CMD_PRE, 3'h1, 14'h0000, 1'b0);
        wait_on(2, 8'h20, "single close");
        i_ctrl.issue(1'b1, 1'b0, CMD_WR, 3'h5, 14'h13FF, 1'b0);
        wait_on(1, 8'h00, "no write");
        chk(acc.write === 1'b1 && acc.col === 10'h3FF && acc.chop === 1'b0, "wr fields");
        chk(acc.close_after_access === 1'b0, "wr no ap");
        repeat (3) @(posedge clk);
        #1;
        chk(banks === 8'h20, "bank kept open");
        i_ctrl.issue(1'b1, 1'b0, CMD_PRE, 3'h0, 14'h0400, 1'b0);
        wait_on(2, 8'h00, "all close");
    endtask

    task automatic t_deselect();
        logic seen;
        seen = 1'b0;
        i_ctrl.issue(1'b1, 1'b1, CMD_ACT, 3'h3, 14'h0123, 1'b0);
        repeat (5) begin
            @(posedge clk);
            #1;
            if (act.valid !== 1'b0 || banks !== 8'h00) seen = 1'b1;
        end
        chk(!seen, "deselected command taken");
    endtask

    task automatic t_power();
        i_ctrl.issue(1'b1, 1'b0, CMD_ACT, 3'h0, 14'h0001, 1'b0);
        wait_on(2, 8'h01, "row not open");
        i_ctrl.set_cke(1'b0);
        wait_on(3, 8'(DDRAC_APD), "no active pd");
        chk(clocks_on === 1'b0, "clocks left on");
        i_ctrl.set_cke(1'b1);
        wait_on(3, 8'(DDRAC_ACTIVE), "no pd exit");
        chk(clocks_on === 1'b1, "clocks off");
        i_ctrl.issue(1'b1, 1'b0, CMD_PRE, 3'h0, 14'h0400, 1'b0);
        wait_on(2, 8'h00, "all close");
        i_ctrl.set_cke(1'b0);
        wait_on(3, 8'(DDRAC_PPD), "no precharge pd");
        i_ctrl.set_cke(1'b1);
        wait_on(3, 8'(DDRAC_ACTIVE), "no pd exit");
        i_ctrl.issue(1'b0, 1'b0, CMD_REF, 3'h0, 14'h0000, 1'b1);
        wait_on(3, 8'(DDRAC_SREF), "no self refresh");
        chk(cmd_buf_on === 1'b0 && term_on === 1'b1, "sref buffers");
        i_ctrl.set_cke(1'b1);
        wait_on(3, 8'(DDRAC_ACTIVE), "no sref exit");
        chk(cmd_buf_on === 1'b1, "buffers off");
    endtask

    // Low enable freezes every flop, so a command or cke drop seen only then is lost
    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0;
        i_ctrl.issue(1'b1, 1'b0, CMD_ACT, 3'h6, 14'h0066, 1'b0);
        i_ctrl.set_cke(1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk(act.valid === 1'b0 && banks === 8'h00 && pwr === DDRAC_ACTIVE, "moved frozen");
        i_ctrl.set_cke(1'b1);
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(act.valid === 1'b0 && banks === 8'h00 && pwr === DDRAC_ACTIVE, "frozen cmd");
    endtask

    initial begin
        errors   = 0;
        compares = 0;
        rst      = 1'b1;
        ce       = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_act_read();
        t_precharge();
        t_deselect();
        t_freeze();
        t_power();
        finish_test();
    end
endmodule // ddrac_top_tb_top
